// ==== smps_pkg.sv ====
// constants, encodings and carriers for the stop-mode power sequencer
package smps_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [2:0] ADDR_CTRL1 = 3'h0;
    localparam logic [2:0] ADDR_CTRL2 = 3'h1;
    localparam logic [2:0] ADDR_CLKCFG = 3'h2;
    localparam logic [2:0] ADDR_USBCFG = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;

    // control 1 fields
    localparam int C1_STOP_INSTRUCTION_ENABLE = 0;
    localparam int C1_LOW_VOLT_DETECT_ENABLE = 1;
    localparam int C1_LOW_VOLT_DETECT_STOP_ENABLE = 2;
    localparam int C1_HITRIP = 3;
    localparam logic [7:0] CTRL1_RESET = 8'h06;

    // control 2 fields
    localparam int C2_DEEPSEL = 0;
    localparam int C2_WAKEFLAG = 3;
    localparam int C2_ACK = 4;

    // clock configuration fields
    localparam int CK_IREFST = 0;
    localparam int CK_EREFST = 1;
    localparam int CK_RANGE = 2;
    localparam int CK_RTC_PRESCALE_SELECT_LO = 4;
    localparam int CK_RTC_PRESCALE_SELECT_HI = 7;
    localparam logic [7:0] CLKCFG_RESET = 8'h00;

    // usb / rtc configuration fields
    localparam int UC_USB_MODULE_ENABLE = 0;
    localparam int UC_PHYEN = 1;
    localparam int UC_RTCIE = 2;
    localparam logic [7:0] USBCFG_RESET = 8'h00;

    // status fields
    localparam int ST_MODE_LO = 0;
    localparam int ST_MODE_HI = 1;
    localparam int ST_HOLD = 2;

    localparam logic [3:0] RTC_PRESCALE_SELECT_OFF = 4'h0;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int WAKE_HOLD_NS = 1000;
    localparam int WAKE_HOLD_CYCLES = (WAKE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_STOP3 = 2'b01,
        MODE_STOP2 = 2'b10,
        MODE_WAKE = 2'b11
    } smps_mode_e;

    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_ON = 2'b10
    } smps_pwr_e;

    typedef struct packed {
        smps_pwr_e core;
        smps_pwr_e ram;
        smps_pwr_e regulator;
        smps_pwr_e clockGenerator;
        smps_pwr_e rtc;
        smps_pwr_e crystalOscillator;
        smps_pwr_e usb;
    } smps_pwr_s;

    typedef struct packed {
        logic periphClkEn;
        logic debugClkEn;
        logic busClkEn;
    } smps_clk_s;

endpackage

// ==== smps_sequencer.sv ====
// stop-mode power sequencer: mode selection, pin latching, wakeup and gating
//
// Functional notes
// - deep power-down removes power from core logic, RAM stays powered.
// - entering deep power-down latches all pin controls for the whole period.
// - reset pin or IRQ pin wakes the device from deep power-down.
// - enabled real-time counter interrupt also wakes deep power-down.
// - deep power-down wakeup acts as power-on reset of registers and CPU.
// - after wakeup low-voltage reset is on, low trip, held while supply low.
// - every deep power-down wakeup sets the recovery flag.
// - flag and pin latches hold until software writes one to acknowledge.
// - on acknowledge, general-purpose pins take their port register values.
// - on acknowledge, pins of disabled peripherals follow port control registers.
// - any stop mode gates peripheral clocks, even with debug enabled.
// - deep power-down turns blocks off, RAM standby; lighter stop keeps standby.
// - lighter stop keeps clock generator running only if internal-reference stop set.
// - real-time counter runs in stop only if prescale was nonzero at entry.
// - lighter stop runs oscillator on external-reference stop; high range needs detector.
// - USB stays powered in stop only with module and transceiver enables set.
// - stop instruction with stop disabled causes illegal opcode reset.
// - deep power-down request with detector enabled in stop enters lighter stop.
//
// The register addresses and strobed register access were left to the implementer.
module smps_sequencer #(
    parameter int PIN_COUNT = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic stopExec,
    input wire logic debugModeEnable,
    input wire logic resetPinAsserted,
    input wire logic irqPinAsserted,
    input wire logic rtcEvent,
    input wire logic intRequest,
    input wire logic supplyBelowTrip,
    input wire logic [PIN_COUNT-1:0] portData,
    input wire logic [PIN_COUNT-1:0] portDir,
    input wire logic [PIN_COUNT-1:0] periphEnable,
    input wire logic [PIN_COUNT-1:0] periphData,
    input wire logic [PIN_COUNT-1:0] periphOe,
    output logic [PIN_COUNT-1:0] pinOut,
    output logic [PIN_COUNT-1:0] pinOe,
    output logic pinLatchHold,
    output logic sysReset,
    output logic illegalOpReset,
    output logic lvdResetEnable,
    output logic lvdHighTrip,
    output smps_pkg::smps_clk_s clkEn,
    output smps_pkg::smps_pwr_s pwrState,
    output smps_pkg::smps_mode_e modeState
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    smps_pkg::smps_mode_e mode_q, mode_d;
    logic [7:0] ctrl1_q, ctrl1_d;
    logic deepSel_q, deepSel_d;
    logic wakeFlag_q, wakeFlag_d;
    logic [7:0] clkCfg_q, clkCfg_d;
    logic [7:0] usbCfg_q, usbCfg_d;
    logic [smps_pkg::CNT_W-1:0] holdCnt_q, holdCnt_d;
    logic rtcRun_q, rtcRun_d;
    logic hold_q, hold_d;
    logic [PIN_COUNT-1:0] latOut_q, latOut_d, latOe_q, latOe_d;
    logic [PIN_COUNT-1:0] pinOut_d, pinOe_d;
    logic [7:0] rdata_d;
    logic sysReset_d, illegal_d;
    smps_pkg::smps_clk_s clk_d;
    smps_pkg::smps_pwr_s pwr_d;

    logic lvdStop, deepAllowed, stop2Wake, ackWrite;
    logic [PIN_COUNT-1:0] liveOut, liveOe;

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        lvdStop = ctrl1_q[smps_pkg::C1_LOW_VOLT_DETECT_ENABLE] && ctrl1_q[smps_pkg::C1_LOW_VOLT_DETECT_STOP_ENABLE];
        deepAllowed = deepSel_q && !lvdStop && !debugModeEnable;
        stop2Wake = resetPinAsserted || irqPinAsserted
            || (rtcEvent && rtcRun_q && usbCfg_q[smps_pkg::UC_RTCIE]);
        ackWrite = regWrite && regAddr == smps_pkg::ADDR_CTRL2
            && regWdata[smps_pkg::C2_ACK];
        // live pin source
        liveOut = (periphEnable & periphData) | (~periphEnable & portData);
        liveOe = (periphEnable & periphOe) | (~periphEnable & portDir);

        mode_d = mode_q;
        ctrl1_d = ctrl1_q;
        deepSel_d = deepSel_q;
        wakeFlag_d = wakeFlag_q;
        clkCfg_d = clkCfg_q;
        usbCfg_d = usbCfg_q;
        holdCnt_d = holdCnt_q;
        rtcRun_d = rtcRun_q;
        hold_d = hold_q;
        latOut_d = latOut_q;
        latOe_d = latOe_q;
        sysReset_d = 1'b0;
        illegal_d = 1'b0;

        // writes only land in run
        if (mode_q == smps_pkg::MODE_RUN && regWrite) begin
            case (regAddr)
                smps_pkg::ADDR_CTRL1: ctrl1_d = regWdata;
                smps_pkg::ADDR_CTRL2: deepSel_d = regWdata[smps_pkg::C2_DEEPSEL];
                smps_pkg::ADDR_CLKCFG: clkCfg_d = regWdata;
                smps_pkg::ADDR_USBCFG: usbCfg_d = regWdata;
                default: ;
            endcase
            if (ackWrite) begin
                wakeFlag_d = 1'b0;
                hold_d = 1'b0;
            end
        end

        case (mode_q)
            smps_pkg::MODE_RUN: begin
                if (stopExec) begin
                    if (!ctrl1_q[smps_pkg::C1_STOP_INSTRUCTION_ENABLE]) begin
                        illegal_d = 1'b1;
                    end else begin
                        rtcRun_d = clkCfg_q[smps_pkg::CK_RTC_PRESCALE_SELECT_HI:smps_pkg::CK_RTC_PRESCALE_SELECT_LO]
                            != smps_pkg::RTC_PRESCALE_SELECT_OFF;
                        if (deepAllowed) begin
                            mode_d = smps_pkg::MODE_STOP2;
                            hold_d = 1'b1;
                            if (!hold_q) begin
                                latOut_d = liveOut;
                                latOe_d = liveOe;
                            end
                        end else begin
                            mode_d = smps_pkg::MODE_STOP3;
                        end
                    end
                end
            end
            smps_pkg::MODE_STOP3: begin
                if (resetPinAsserted) begin
                    mode_d = smps_pkg::MODE_WAKE;
                    holdCnt_d = smps_pkg::CNT_W'(smps_pkg::WAKE_HOLD_CYCLES);
                    sysReset_d = 1'b1;
                end else if (intRequest) begin
                    mode_d = smps_pkg::MODE_RUN;
                end
            end
            smps_pkg::MODE_STOP2: begin
                if (stop2Wake) begin
                    mode_d = smps_pkg::MODE_WAKE;
                    holdCnt_d = smps_pkg::CNT_W'(smps_pkg::WAKE_HOLD_CYCLES);
                    sysReset_d = 1'b1;
                    wakeFlag_d = 1'b1;
                    ctrl1_d = smps_pkg::CTRL1_RESET;
                    deepSel_d = 1'b0;
                    clkCfg_d = smps_pkg::CLKCFG_RESET;
                    usbCfg_d = smps_pkg::USBCFG_RESET;
                end
            end
            smps_pkg::MODE_WAKE: begin
                sysReset_d = 1'b1;
                if (holdCnt_q != '0) begin
                    holdCnt_d = holdCnt_q - 1'b1;
                end else if (!supplyBelowTrip) begin
                    mode_d = smps_pkg::MODE_RUN;
                    sysReset_d = 1'b0;
                end
            end
            default: mode_d = smps_pkg::MODE_RUN;
        endcase

        // pins: latched or live
        pinOut_d = hold_d ? latOut_d : liveOut;
        pinOe_d = hold_d ? latOe_d : liveOe;
    end

    // ---------------------------------------------------------------
    // clock gating and power states
    // ---------------------------------------------------------------
    always_comb begin
        clk_d = '1;
        pwr_d = '{default: smps_pkg::PWR_ON};
        case (mode_d)
            smps_pkg::MODE_STOP3: begin
                clk_d.periphClkEn = 1'b0;
                clk_d.busClkEn = 1'b0;
                clk_d.debugClkEn = debugModeEnable;
                pwr_d.core = smps_pkg::PWR_STANDBY;
                pwr_d.ram = smps_pkg::PWR_STANDBY;
                pwr_d.regulator = (lvdStop || debugModeEnable)
                    ? smps_pkg::PWR_ON : smps_pkg::PWR_STANDBY;
                pwr_d.clockGenerator = clkCfg_q[smps_pkg::CK_IREFST]
                    ? smps_pkg::PWR_ON : smps_pkg::PWR_STANDBY;
                pwr_d.rtc = rtcRun_d ? smps_pkg::PWR_ON : smps_pkg::PWR_OFF;
                pwr_d.crystalOscillator = (clkCfg_q[smps_pkg::CK_EREFST]
                    && (!clkCfg_q[smps_pkg::CK_RANGE] || lvdStop))
                    ? smps_pkg::PWR_ON : smps_pkg::PWR_STANDBY;
                pwr_d.usb = (usbCfg_q[smps_pkg::UC_USB_MODULE_ENABLE] && usbCfg_q[smps_pkg::UC_PHYEN])
                    ? smps_pkg::PWR_ON : smps_pkg::PWR_OFF;
            end
            smps_pkg::MODE_STOP2: begin
                clk_d.periphClkEn = 1'b0;
                clk_d.busClkEn = 1'b0;
                clk_d.debugClkEn = 1'b0;
                pwr_d.core = smps_pkg::PWR_OFF;
                pwr_d.ram = smps_pkg::PWR_STANDBY;
                pwr_d.regulator = smps_pkg::PWR_OFF;
                pwr_d.clockGenerator = smps_pkg::PWR_OFF;
                pwr_d.rtc = rtcRun_d ? smps_pkg::PWR_ON : smps_pkg::PWR_OFF;
                pwr_d.crystalOscillator = smps_pkg::PWR_OFF;
                pwr_d.usb = (usbCfg_q[smps_pkg::UC_USB_MODULE_ENABLE] && usbCfg_q[smps_pkg::UC_PHYEN])
                    ? smps_pkg::PWR_ON : smps_pkg::PWR_OFF;
            end
            smps_pkg::MODE_WAKE: begin
                clk_d.periphClkEn = 1'b0;
                clk_d.debugClkEn = 1'b0;
            end
            default: ;
        endcase
    end

    // ---------------------------------------------------------------
    // read data, one cycle after strobe
    // ---------------------------------------------------------------
    always_comb begin
        rdata_d = smps_pkg::DATA_ZERO;
        if (regRead) begin
            case (regAddr)
                smps_pkg::ADDR_CTRL1: rdata_d = ctrl1_q;
                smps_pkg::ADDR_CTRL2: begin
                    rdata_d[smps_pkg::C2_DEEPSEL] = deepSel_q;
                    rdata_d[smps_pkg::C2_WAKEFLAG] = wakeFlag_q;
                end
                smps_pkg::ADDR_CLKCFG: rdata_d = clkCfg_q;
                smps_pkg::ADDR_USBCFG: rdata_d = usbCfg_q;
                smps_pkg::ADDR_STATUS: begin
                    rdata_d[smps_pkg::ST_MODE_HI:smps_pkg::ST_MODE_LO] = mode_q;
                    rdata_d[smps_pkg::ST_HOLD] = hold_q;
                end
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_q <= smps_pkg::MODE_RUN;
            ctrl1_q <= smps_pkg::CTRL1_RESET;
            deepSel_q <= 1'b0;
            wakeFlag_q <= 1'b0;
            clkCfg_q <= smps_pkg::CLKCFG_RESET;
            usbCfg_q <= smps_pkg::USBCFG_RESET;
            holdCnt_q <= '0;
            rtcRun_q <= 1'b0;
            hold_q <= 1'b0;
            latOut_q <= '0;
            latOe_q <= '0;
            pinOut <= '0;
            pinOe <= '0;
            pinLatchHold <= 1'b0;
            sysReset <= 1'b0;
            illegalOpReset <= 1'b0;
            lvdResetEnable <= 1'b1;
            lvdHighTrip <= 1'b0;
            regRdata <= smps_pkg::DATA_ZERO;
            clkEn <= '1;
            pwrState <= '{default: smps_pkg::PWR_ON};
            modeState <= smps_pkg::MODE_RUN;
        end else begin
            mode_q <= mode_d;
            ctrl1_q <= ctrl1_d;
            deepSel_q <= deepSel_d;
            wakeFlag_q <= wakeFlag_d;
            clkCfg_q <= clkCfg_d;
            usbCfg_q <= usbCfg_d;
            holdCnt_q <= holdCnt_d;
            rtcRun_q <= rtcRun_d;
            hold_q <= hold_d;
            latOut_q <= latOut_d;
            latOe_q <= latOe_d;
            pinOut <= pinOut_d;
            pinOe <= pinOe_d;
            pinLatchHold <= hold_d;
            sysReset <= sysReset_d;
            illegalOpReset <= illegal_d;
            lvdResetEnable <= ctrl1_d[smps_pkg::C1_LOW_VOLT_DETECT_ENABLE];
            lvdHighTrip <= ctrl1_d[smps_pkg::C1_HITRIP];
            regRdata <= rdata_d;
            clkEn <= clk_d;
            pwrState <= pwr_d;
            modeState <= mode_d;
        end
    end

endmodule

// ==== smps_sequencer_sva.sv ====
// concurrent checks on the stop-mode power sequencer ports
module smps_sequencer_sva #(
    parameter int PIN_COUNT = 8
) (
    input logic core_clk,
    input logic rst,
    input logic [2:0] regAddr,
    input logic [7:0] regWdata,
    input logic regWrite,
    input logic regRead,
    input logic [7:0] regRdata,
    input logic stopExec,
    input logic resetPinAsserted,
    input logic irqPinAsserted,
    input logic [PIN_COUNT-1:0] portData,
    input logic [PIN_COUNT-1:0] portDir,
    input logic [PIN_COUNT-1:0] periphEnable,
    input logic [PIN_COUNT-1:0] periphData,
    input logic [PIN_COUNT-1:0] periphOe,
    input logic [PIN_COUNT-1:0] pinOut,
    input logic [PIN_COUNT-1:0] pinOe,
    input logic pinLatchHold,
    input logic sysReset,
    input logic illegalOpReset,
    input logic lvdResetEnable,
    input logic lvdHighTrip,
    input smps_pkg::smps_clk_s clkEn,
    input smps_pkg::smps_pwr_s pwrState,
    input smps_pkg::smps_mode_e modeState
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    wire logic ackWr = regWrite && regAddr == smps_pkg::ADDR_CTRL2 && regWdata[4];
    property p_illegal;
        illegalOpReset |-> $past(stopExec) && $past(modeState) == smps_pkg::MODE_RUN;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal reset without stop");
    property p_gate;
        modeState inside {smps_pkg::MODE_STOP2, smps_pkg::MODE_STOP3} |-> !clkEn.periphClkEn;
    endproperty
    a_gate: assert property (p_gate) else $error("peripheral clock runs in stop");
    property p_deep;
        modeState == smps_pkg::MODE_STOP2 |-> pwrState.core == smps_pkg::PWR_OFF
            && pwrState.ram == smps_pkg::PWR_STANDBY && pwrState.regulator == smps_pkg::PWR_OFF;
    endproperty
    a_deep: assert property (p_deep) else $error("deep stop power map wrong");
    property p_light;
        modeState == smps_pkg::MODE_STOP3 |-> pwrState.core == smps_pkg::PWR_STANDBY;
    endproperty
    a_light: assert property (p_light) else $error("light stop core not standby");
    property p_frozen;
        pinLatchHold && $past(pinLatchHold) |-> $stable(pinOut) && $stable(pinOe);
    endproperty
    a_frozen: assert property (p_frozen) else $error("pins moved while held");
    property p_wake;
        modeState == smps_pkg::MODE_STOP2 && (resetPinAsserted || irqPinAsserted)
            |=> modeState == smps_pkg::MODE_WAKE && sysReset;
    endproperty
    a_wake: assert property (p_wake) else $error("wake pin ignored");
    property p_por;
        modeState == smps_pkg::MODE_WAKE && $past(modeState) == smps_pkg::MODE_WAKE
            |-> sysReset && lvdResetEnable && !lvdHighTrip;
    endproperty
    a_por: assert property (p_por) else $error("wake not reset like");
    property p_keep;
        pinLatchHold && modeState != smps_pkg::MODE_STOP3 && !ackWr |=> pinLatchHold;
    endproperty
    a_keep: assert property (p_keep) else $error("hold dropped without ack");
    property p_open;
        ackWr && modeState == smps_pkg::MODE_RUN |=> !pinLatchHold;
    endproperty
    a_open: assert property (p_open) else $error("ack did not open latches");
    property p_ack0;
        regRead && regAddr == smps_pkg::ADDR_CTRL2 |=> !regRdata[4];
    endproperty
    a_ack0: assert property (p_ack0) else $error("ack bit read nonzero");
    property p_live;
        !pinLatchHold && !$past(pinLatchHold) && !$past(rst)
            |-> pinOut == $past((periphEnable & periphData) | (~periphEnable & portData))
            && pinOe == $past((periphEnable & periphOe) | (~periphEnable & portDir));
    endproperty
    a_live: assert property (p_live) else $error("open pins not live");
    c_deep: cover property (modeState == smps_pkg::MODE_STOP2);
    c_wake: cover property (sysReset);
    c_illegal: cover property (illegalOpReset);
endmodule

bind smps_sequencer smps_sequencer_sva #(.PIN_COUNT(PIN_COUNT)) u_sva (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .stopExec(stopExec),
    .resetPinAsserted(resetPinAsserted), .irqPinAsserted(irqPinAsserted),
    .portData(portData), .portDir(portDir), .periphEnable(periphEnable),
    .periphData(periphData), .periphOe(periphOe), .pinOut(pinOut), .pinOe(pinOe),
    .pinLatchHold(pinLatchHold), .sysReset(sysReset), .illegalOpReset(illegalOpReset),
    .lvdResetEnable(lvdResetEnable), .lvdHighTrip(lvdHighTrip), .clkEn(clkEn),
    .pwrState(pwrState), .modeState(modeState));

// ==== smps_pins_model.sv ====
// pin-side partner: wakeup pins and live port/peripheral pin sources
module smps_pins_model #(
    parameter int PIN_COUNT = 8
) (
    input logic core_clk,
    input logic [1:0] wakeReq,
    output logic resetPinAsserted,
    output logic irqPinAsserted,
    output logic [PIN_COUNT-1:0] portData,
    output logic [PIN_COUNT-1:0] portDir,
    output logic [PIN_COUNT-1:0] periphEnable,
    output logic [PIN_COUNT-1:0] periphData,
    output logic [PIN_COUNT-1:0] periphOe
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge core_clk) begin
        // wake pads only sensed
        resetPinAsserted <= wakeReq[0];
        irqPinAsserted <= wakeReq[1];
        // sources change every cycle
        portData <= PIN_COUNT'($urandom);
        portDir <= PIN_COUNT'($urandom);
        periphEnable <= PIN_COUNT'($urandom);
        periphData <= PIN_COUNT'($urandom);
        periphOe <= PIN_COUNT'($urandom);
    end
endmodule

// ==== smps_sequencer_test.sv ====
// self-checking testbench for the stop-mode power sequencer
module smps_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0, regRead = 1'b0, stopExec = 1'b0, debugModeEnable = 1'b0;
    logic rtcEvent = 1'b0, intRequest = 1'b0, supplyBelowTrip = 1'b0, rdSeen = 1'b0;
    logic [1:0] wakeReq = 2'h0;
    logic resetPinAsserted, irqPinAsserted, pinLatchHold, sysReset, illegalOpReset;
    logic lvdResetEnable, lvdHighTrip;
    logic [7:0] portData, portDir, periphEnable, periphData, periphOe, pinOut, pinOe, regRdata;
    logic [7:0] ck, uc, held, eOut, eOe;
    logic [7:0] expQ[$];
    logic [7:0] c1Tab[3] = '{8'h07, 8'h01, 8'h01};
    logic [1:0] sTab[3] = '{2'h1, 2'h3, 2'h0};
    smps_pkg::smps_clk_s clkEn;
    smps_pkg::smps_pwr_s pwrState;
    smps_pkg::smps_mode_e modeState;
    int mismatches = 0, num_checks = 0;
    always #10 core_clk = ~core_clk;
    smps_sequencer #(.PIN_COUNT(8)) uut (
        .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .stopExec(stopExec),
        .debugModeEnable(debugModeEnable), .resetPinAsserted(resetPinAsserted),
        .irqPinAsserted(irqPinAsserted), .rtcEvent(rtcEvent), .intRequest(intRequest),
        .supplyBelowTrip(supplyBelowTrip), .portData(portData), .portDir(portDir),
        .periphEnable(periphEnable), .periphData(periphData), .periphOe(periphOe),
        .pinOut(pinOut), .pinOe(pinOe), .pinLatchHold(pinLatchHold), .sysReset(sysReset),
        .illegalOpReset(illegalOpReset), .lvdResetEnable(lvdResetEnable),
        .lvdHighTrip(lvdHighTrip), .clkEn(clkEn), .pwrState(pwrState), .modeState(modeState));
    smps_pins_model #(.PIN_COUNT(8)) pins (
        .core_clk(core_clk), .wakeReq(wakeReq), .resetPinAsserted(resetPinAsserted),
        .irqPinAsserted(irqPinAsserted), .portData(portData), .portDir(portDir),
        .periphEnable(periphEnable), .periphData(periphData), .periphOe(periphOe));
    // ---------------------------------------------------------------
    // bus tasks and comparison
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
        num_checks++;
        if (got !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        expQ.push_back(e);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic stopPulse;
        stopExec <= 1'b1;
        @(posedge core_clk);
        stopExec <= 1'b0;
        #1;
    endtask
    task automatic waitMode(input smps_pkg::smps_mode_e m, input int lim);
        for (int n = 0; n < lim && modeState !== m; n++) @(posedge core_clk);
        #1 chk("modeState", m, modeState);
        @(posedge core_clk);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // read data checked one cycle after strobe
    always @(posedge core_clk) begin
        if (rdSeen) chk("regRdata", expQ.pop_front(), regRdata);
        rdSeen <= regRead;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        end_sim();
    end
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'hA9BF555B));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int a = 0; a < 8; a++) rd(3'(a), (a == 0) ? 8'h06 : 8'h00);
        stopPulse();
        chk("illegalOpReset", 8'h01, illegalOpReset);
        chk("modeState", smps_pkg::MODE_RUN, modeState);
        $display("reset test done");
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            ck = 8'($urandom) & 8'hF7;
            uc = 8'($urandom) & 8'h03;
            wr(smps_pkg::ADDR_CTRL1, c1Tab[i]);
            wr(smps_pkg::ADDR_CTRL2, {7'h00, sTab[i][0]});
            wr(smps_pkg::ADDR_CLKCFG, ck);
            wr(smps_pkg::ADDR_USBCFG, uc);
            rd(smps_pkg::ADDR_CLKCFG, ck);
            debugModeEnable <= sTab[i][1];
            stopPulse();
            chk("modeState", smps_pkg::MODE_STOP3, modeState);
            chk("periphClkEn", 8'h00, clkEn.periphClkEn);
            chk("debugClkEn", sTab[i][1], clkEn.debugClkEn);
            chk("core", smps_pkg::PWR_STANDBY, pwrState.core);
            chk("clkGen", ck[0] ? smps_pkg::PWR_ON : smps_pkg::PWR_STANDBY,
                pwrState.clockGenerator);
            chk("rtc", (ck[7:4] != 4'h0) ? smps_pkg::PWR_ON : smps_pkg::PWR_OFF,
                pwrState.rtc);
            chk("osc", (ck[1] && (!ck[2] || c1Tab[i][2:1] == 2'h3)) ? smps_pkg::PWR_ON
                : smps_pkg::PWR_STANDBY, pwrState.crystalOscillator);
            chk("usb", (&uc[1:0]) ? smps_pkg::PWR_ON : smps_pkg::PWR_OFF, pwrState.usb);
            if (!sTab[i][1]) chk("regulator", (c1Tab[i] == 8'h07) ? smps_pkg::PWR_ON
                : smps_pkg::PWR_STANDBY, pwrState.regulator);
            @(posedge core_clk);
            intRequest <= 1'b1;
            debugModeEnable <= 1'b0;
            @(posedge core_clk);
            intRequest <= 1'b0;
            waitMode(smps_pkg::MODE_RUN, 3);
        end
        $display("light stop test done");
        for (int s = 0; s < 3; s++) begin
            wr(smps_pkg::ADDR_CTRL1, 8'h01);
            wr(smps_pkg::ADDR_CTRL2, 8'h01);
            wr(smps_pkg::ADDR_CLKCFG, 8'h50);
            wr(smps_pkg::ADDR_USBCFG, 8'h04);
            stopPulse();
            chk("modeState", smps_pkg::MODE_STOP2, modeState);
            chk("hold", 8'h01, pinLatchHold);
            chk("rtc", smps_pkg::PWR_ON, pwrState.rtc);
            held = pinOut;
            repeat (5) @(posedge core_clk);
            #1 chk("pinOut", held, pinOut);
            @(posedge core_clk);
            if (s == 2) rtcEvent <= 1'b1;
            else wakeReq <= (s == 0) ? 2'h1 : 2'h2;
            supplyBelowTrip <= (s == 0);
            waitMode(smps_pkg::MODE_WAKE, 4);
            rtcEvent <= 1'b0;
            wakeReq <= 2'h0;
            repeat (70) @(posedge core_clk);
            #1 chk("modeState", (s == 0) ? smps_pkg::MODE_WAKE : smps_pkg::MODE_RUN,
                modeState);
            @(posedge core_clk);
            supplyBelowTrip <= 1'b0;
            waitMode(smps_pkg::MODE_RUN, 80);
            chk("lvdResetEnable", 8'h01, lvdResetEnable);
            chk("lvdHighTrip", 8'h00, lvdHighTrip);
            rd(smps_pkg::ADDR_CTRL2, 8'h08);
            rd(smps_pkg::ADDR_CTRL1, 8'h06);
            rd(smps_pkg::ADDR_CLKCFG, 8'h00);
            rd(smps_pkg::ADDR_STATUS, 8'h04);
            wr(smps_pkg::ADDR_CTRL2, 8'h10);
            chk("hold", 8'h00, pinLatchHold);
            rd(smps_pkg::ADDR_CTRL2, 8'h00);
            eOut = (periphEnable & periphData) | (~periphEnable & portData);
            eOe = (periphEnable & periphOe) | (~periphEnable & portDir);
            #1 chk("pinOut", eOut, pinOut);
            chk("pinOe", eOe, pinOe);
            @(posedge core_clk);
        end
        $display("deep stop test done");
        end_sim();
    end
endmodule
